//--- logic/srbsc_pkg.sv
/*
  Constants shared by the reset and strap control block: register map,
  field positions, strap mode codes, state codes and timing counts.
  Assumes a 125 MHz core clock on pclk.
*/
`default_nettype none
package srbsc_pkg;
  // ------------------------------------------------------------
  // Clock and timing
  // ------------------------------------------------------------
  localparam int CLK_HZ = 125_000_000;
  localparam int SMB_SLOW_HZ = 100_000;
  localparam int SMB_FAST_HZ = 400_000;
  localparam int DIV_W = 11;
  // Shortest period rounds down
  localparam logic [DIV_W-1:0] SMB_SLOW_CYC = DIV_W'(CLK_HZ / SMB_SLOW_HZ);
  localparam logic [DIV_W-1:0] SMB_FAST_CYC = DIV_W'(CLK_HZ / SMB_FAST_HZ);
  localparam int RESET_PROC_NS = 1000;
  localparam int CLK_MHZ = CLK_HZ / 1_000_000;
  localparam int PROC_W = 8;
  // Least time rounds up
  localparam logic [PROC_W-1:0] RESET_PROC_CYC =
    PROC_W'((RESET_PROC_NS * CLK_MHZ + 999) / 1000);

  // ------------------------------------------------------------
  // Register map (byte addresses)
  // ------------------------------------------------------------
  localparam int ADDR_W = 12;
  localparam logic [ADDR_W-1:0] OFS_SWITCH_CTRL = 12'h000;
  localparam logic [ADDR_W-1:0] OFS_UP_LINK_STS = 12'h004;
  localparam logic [ADDR_W-1:0] OFS_DN2_LINK_STS = 12'h008;
  localparam logic [ADDR_W-1:0] OFS_DN4_LINK_STS = 12'h00c;
  localparam logic [ADDR_W-1:0] OFS_STRAP_STS = 12'h010;

  // Field positions
  localparam int HALT_BIT = 0;
  localparam int SCLK_BIT = 12;
  localparam int STS_MODE_LSB = 0;
  localparam int STS_EEP_INIT_BIT = 3;
  localparam int STS_RSVD_BIT = 4;
  localparam int STS_SLOW_BIT = 5;
  localparam int STS_HALT_STRAP_BIT = 6;
  localparam int STS_EEP_ADDR_LSB = 8;
  localparam int STS_STATE_LSB = 12;

  // Switch mode strap codes
  localparam logic [2:0] MODE_NORMAL = 3'h0;
  localparam logic [2:0] MODE_EEPROM = 3'h1;
  localparam int DN_PORTS = 2;

  typedef enum logic [1:0] {
    ST_RESET = 2'b00,
    ST_PROC = 2'b01,
    ST_HALT = 2'b10,
    ST_RUN = 2'b11
  } srbsc_state_t;
endpackage
`default_nettype wire

//--- logic/srbsc_rate_tick.sv
/*
  Rate divider giving a one-cycle enable pulse for the master SMBus.
  Assumes slow is held static while enable is high.
*/
`timescale 1ns/1ns
`default_nettype none
module srbsc_rate_tick #(
  parameter int DIV_W = srbsc_pkg::DIV_W,
  parameter logic [DIV_W-1:0] SLOW_CYC = srbsc_pkg::SMB_SLOW_CYC,
  parameter logic [DIV_W-1:0] FAST_CYC = srbsc_pkg::SMB_FAST_CYC
) (
  input wire logic pclk, // Core clock
  input wire logic presetn, // Async reset, active low
  input wire logic enable, // Divider runs while high
  input wire logic slow, // Select slow rate
  output logic tick // One-cycle rate pulse
);
  typedef struct packed {
    logic [DIV_W-1:0] cnt;
    logic tick;
  } srbsc_tick_t;

  srbsc_tick_t s, next_s;
  logic [DIV_W-1:0] reload;

  always_comb begin
    reload = slow ? SLOW_CYC - 1'b1 : FAST_CYC - 1'b1;
    next_s = s;
    next_s.tick = 1'b0;
    if (!enable) begin
      next_s.cnt = reload;
    end else if (s.cnt == '0) begin
      next_s.cnt = reload;
      next_s.tick = 1'b1;
    end else begin
      next_s.cnt = s.cnt - 1'b1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign tick = s.tick;
endmodule
`default_nettype wire

//--- logic/srbsc_top.sv
/*
  Reset and boot strap control for a three-port packet switch, with an
  APB slave for the control and link status registers.
  Assumes strap pins and fundamental_reset_n are synchronous to pclk.
*/
// The APB interface to the registers and the register offsets were decided locally.
`timescale 1ns/1ns
`default_nettype none
module srbsc_top (
  input wire logic pclk, // Core clock
  input wire logic presetn, // Async reset, active low
  input wire logic psel, // APB select
  input wire logic penable, // APB enable
  input wire logic pwrite, // APB direction
  input wire logic [11:0] paddr, // APB byte address
  input wire logic [31:0] pwdata, // APB write data
  output logic [31:0] prdata, // APB read data
  output logic pready, // APB ready
  output logic pslverr, // APB error
  input wire logic fundamental_reset_n, // Fundamental reset, active low
  input wire logic downstream_common_clock_strap, // Downstream common clock
  input wire logic upstream_common_clock_strap, // Upstream common clock
  input wire logic master_smbus_slow_strap, // Master SMBus slow mode
  input wire logic reset_halt_strap, // Hold after reset
  input wire logic [2:0] switch_op_mode_strap, // Switch mode
  input wire logic [3:0] eeprom_smbus_address_strap, // EEPROM address
  output logic switch_reset_n, // Switch core reset, active low
  output logic pcie_fund_reset_start, // Fundamental reset begun pulse
  output logic smbus_enable, // SMBus interfaces active
  output logic msmb_tick, // Master SMBus rate pulse
  output logic msmb_slow, // Master SMBus in slow mode
  output logic eeprom_init_mode, // EEPROM load selected
  output logic mode_reserved, // Reserved mode code strapped
  output logic [3:0] eeprom_smbus_address, // EEPROM SMBus address
  output logic upstream_slot_clock, // Upstream slot clock config
  output logic [1:0] downstream_slot_clock // Ports 2 and 4 slot clock
);
  // ------------------------------------------------------------
  // State
  // ------------------------------------------------------------
  typedef struct packed {
    srbsc_pkg::srbsc_state_t state;
    logic [srbsc_pkg::PROC_W-1:0] proc_cnt;
    logic fund_prev;
    logic [2:0] mode;
    logic eep_init;
    logic mode_rsvd;
    logic slow;
    logic halt_strap;
    logic [3:0] eep_addr;
    logic us_clk;
    logic [srbsc_pkg::DN_PORTS-1:0] ds_clk;
    logic halt;
    logic fund_start;
    logic switch_reset_n;
    logic smbus_en;
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
  } srbsc_regs_t;

  srbsc_regs_t s, next_s, bus_s;
  logic wr_commit;
  logic known;

  assign wr_commit = psel && penable && s.pready && pwrite && !s.pslverr;

  always_comb begin
    next_s = s;
    next_s.fund_start = 1'b0;
    next_s.pready = 1'b0;
    next_s.pslverr = 1'b0;
    known = 1'b1;

    // ----------------------------------------------------------
    // APB answer: ready in the first access cycle
    // ----------------------------------------------------------
    if (psel && !penable) begin
      next_s.pready = 1'b1;
      next_s.prdata = '0;
      unique case (paddr)
        srbsc_pkg::OFS_SWITCH_CTRL:
          next_s.prdata[srbsc_pkg::HALT_BIT] = s.halt;
        srbsc_pkg::OFS_UP_LINK_STS:
          next_s.prdata[srbsc_pkg::SCLK_BIT] = s.us_clk;
        srbsc_pkg::OFS_DN2_LINK_STS:
          next_s.prdata[srbsc_pkg::SCLK_BIT] = s.ds_clk[0];
        srbsc_pkg::OFS_DN4_LINK_STS:
          next_s.prdata[srbsc_pkg::SCLK_BIT] = s.ds_clk[1];
        srbsc_pkg::OFS_STRAP_STS: begin
          next_s.prdata[srbsc_pkg::STS_MODE_LSB +: 3] = s.mode;
          next_s.prdata[srbsc_pkg::STS_EEP_INIT_BIT] = s.eep_init;
          next_s.prdata[srbsc_pkg::STS_RSVD_BIT] = s.mode_rsvd;
          next_s.prdata[srbsc_pkg::STS_SLOW_BIT] = s.slow;
          next_s.prdata[srbsc_pkg::STS_HALT_STRAP_BIT] = s.halt_strap;
          next_s.prdata[srbsc_pkg::STS_EEP_ADDR_LSB +: 4] = s.eep_addr;
          next_s.prdata[srbsc_pkg::STS_STATE_LSB +: 2] = s.state;
        end
        default:
          known = 1'b0;
      endcase
      next_s.pslverr = !known;
    end

    // Register writes; the strap status register ignores writes
    if (wr_commit) begin
      unique case (paddr)
        srbsc_pkg::OFS_SWITCH_CTRL: begin
          // Software may only clear the halt bit
          if (!pwdata[srbsc_pkg::HALT_BIT]) begin
            next_s.halt = 1'b0;
          end
        end
        srbsc_pkg::OFS_UP_LINK_STS:
          next_s.us_clk = pwdata[srbsc_pkg::SCLK_BIT];
        srbsc_pkg::OFS_DN2_LINK_STS:
          next_s.ds_clk[0] = pwdata[srbsc_pkg::SCLK_BIT];
        srbsc_pkg::OFS_DN4_LINK_STS:
          next_s.ds_clk[1] = pwdata[srbsc_pkg::SCLK_BIT];
        default: begin
        end
      endcase
    end

    // ----------------------------------------------------------
    // Reset sequencing
    // ----------------------------------------------------------
    next_s.fund_prev = fundamental_reset_n;
    unique case (s.state)
      srbsc_pkg::ST_RESET: begin
        if (fundamental_reset_n) begin
          // Straps caught once, at release
          next_s.state = srbsc_pkg::ST_PROC;
          next_s.proc_cnt = srbsc_pkg::RESET_PROC_CYC;
          next_s.mode = switch_op_mode_strap;
          next_s.eep_init =
            (switch_op_mode_strap == srbsc_pkg::MODE_EEPROM);
          next_s.mode_rsvd =
            (switch_op_mode_strap > srbsc_pkg::MODE_EEPROM);
          next_s.eep_addr = (switch_op_mode_strap == srbsc_pkg::MODE_EEPROM)
            ? eeprom_smbus_address_strap : 4'h0;
          next_s.slow = master_smbus_slow_strap;
          next_s.halt_strap = reset_halt_strap;
          next_s.us_clk = upstream_common_clock_strap;
          next_s.ds_clk =
            {srbsc_pkg::DN_PORTS{downstream_common_clock_strap}};
        end
      end
      srbsc_pkg::ST_PROC: begin
        if (s.proc_cnt == '0) begin
          next_s.smbus_en = 1'b1;
          if (s.halt_strap) begin
            // Hardware set wins over a write in the same cycle
            next_s.state = srbsc_pkg::ST_HALT;
            next_s.halt = 1'b1;
          end else begin
            next_s.state = srbsc_pkg::ST_RUN;
            next_s.switch_reset_n = 1'b1;
          end
        end else begin
          next_s.proc_cnt = s.proc_cnt - 1'b1;
        end
      end
      srbsc_pkg::ST_HALT: begin
        if (!s.halt) begin
          next_s.state = srbsc_pkg::ST_RUN;
          next_s.switch_reset_n = 1'b1;
        end
      end
      srbsc_pkg::ST_RUN: begin
      end
    endcase

    // Fundamental reset clears all but the bus answer and the start pulse
    if (!fundamental_reset_n) begin
      bus_s = next_s;
      next_s = '0;
      next_s.state = srbsc_pkg::ST_RESET;
      next_s.pready = bus_s.pready;
      next_s.pslverr = bus_s.pslverr;
      next_s.prdata = bus_s.prdata;
      next_s.fund_start = s.fund_prev;
    end else begin
      bus_s = next_s;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  // ------------------------------------------------------------
  // Master SMBus rate, fixed by the strap alone
  // ------------------------------------------------------------
  srbsc_rate_tick u_rate (
    .pclk(pclk),
    .presetn(presetn),
    .enable(s.smbus_en),
    .slow(s.slow),
    .tick(msmb_tick)
  );

  assign prdata = s.prdata;
  assign pready = s.pready;
  assign pslverr = s.pslverr;
  assign switch_reset_n = s.switch_reset_n;
  assign pcie_fund_reset_start = s.fund_start;
  assign smbus_enable = s.smbus_en;
  assign msmb_slow = s.slow;
  assign eeprom_init_mode = s.eep_init;
  assign mode_reserved = s.mode_rsvd;
  assign eeprom_smbus_address = s.eep_addr;
  assign upstream_slot_clock = s.us_clk;
  assign downstream_slot_clock = s.ds_clk;

  // ------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  // Helper: cycles since last rate pulse
  logic [srbsc_pkg::DIV_W-1:0] gap;
  logic gap_v;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      gap <= '0;
      gap_v <= 1'b0;
    end else if (!s.smbus_en) begin
      gap <= '0;
      gap_v <= 1'b0;
    end else if (msmb_tick) begin
      gap <= '0;
      gap_v <= 1'b1;
    end else begin
      gap <= gap + 1'b1;
    end
  end

  sequence s_release;
    s.state == srbsc_pkg::ST_RESET && fundamental_reset_n;
  endsequence

  property p_ds_load;
    s_release |=> downstream_slot_clock ==
      {2{$past(downstream_common_clock_strap)}};
  endproperty
  a_ds_load: assert property (p_ds_load)
    else $error("downstream slot clock not loaded from strap");

  property p_ds_write;
    wr_commit && fundamental_reset_n &&
      paddr == srbsc_pkg::OFS_DN4_LINK_STS && s.state != srbsc_pkg::ST_RESET
      |=> downstream_slot_clock[1] == $past(pwdata[srbsc_pkg::SCLK_BIT]);
  endproperty
  a_ds_write: assert property (p_ds_write)
    else $error("downstream slot clock write lost");

  property p_us_load;
    s_release |=> upstream_slot_clock == $past(upstream_common_clock_strap);
  endproperty
  a_us_load: assert property (p_us_load)
    else $error("upstream slot clock not loaded from strap");

  property p_us_write;
    wr_commit && fundamental_reset_n &&
      paddr == srbsc_pkg::OFS_UP_LINK_STS && s.state != srbsc_pkg::ST_RESET
      |=> upstream_slot_clock == $past(pwdata[srbsc_pkg::SCLK_BIT]);
  endproperty
  a_us_write: assert property (p_us_write)
    else $error("upstream slot clock write lost");

  property p_rate;
    msmb_tick && gap_v |-> gap == (msmb_slow ?
      srbsc_pkg::SMB_SLOW_CYC - 1'b1 : srbsc_pkg::SMB_FAST_CYC - 1'b1);
  endproperty
  a_rate: assert property (p_rate)
    else $error("master SMBus rate wrong");

  sequence s_fund_fall;
    fundamental_reset_n ##1 !fundamental_reset_n;
  endsequence

  property p_fund;
    s_fund_fall |=> pcie_fund_reset_start && !switch_reset_n &&
      !smbus_enable ##1 !pcie_fund_reset_start;
  endproperty
  a_fund: assert property (p_fund)
    else $error("fundamental reset not applied");

  property p_halt_hold;
    s.state == srbsc_pkg::ST_HALT |-> !switch_reset_n && smbus_enable;
  endproperty
  a_halt_hold: assert property (p_halt_hold)
    else $error("halted state not held with SMBus active");

  property p_halt_exit;
    s.state == srbsc_pkg::ST_HALT && !s.halt && fundamental_reset_n
      |=> switch_reset_n;
  endproperty
  a_halt_exit: assert property (p_halt_exit)
    else $error("halt not left after bit cleared");

  property p_mode;
    s.state == srbsc_pkg::ST_RUN |-> eeprom_init_mode ==
      (s.mode == srbsc_pkg::MODE_EEPROM) && mode_reserved ==
      (s.mode > srbsc_pkg::MODE_EEPROM);
  endproperty
  a_mode: assert property (p_mode)
    else $error("switch mode decode wrong");

  property p_eep;
    s_release |=> eeprom_smbus_address ==
      ($past(switch_op_mode_strap) == srbsc_pkg::MODE_EEPROM ?
      $past(eeprom_smbus_address_strap) : 4'h0);
  endproperty
  a_eep: assert property (p_eep)
    else $error("EEPROM address not taken from strap");

  property p_keep;
    s.state != srbsc_pkg::ST_RESET && fundamental_reset_n
      |=> $stable(s.mode) && $stable(s.slow) && $stable(s.halt_strap);
  endproperty
  a_keep: assert property (p_keep)
    else $error("sampled straps changed before reset");
endmodule
`default_nettype wire

//--- bench/srbsc_board.sv
/*
  Board side of the reset block: strap pins and fundamental reset driver.
  Assumes the bench changes cfg only while hold is high.
*/
`timescale 1ns/1ns
`default_nettype none
module srbsc_board (
  input wire logic pclk, // Core clock
  input wire logic hold, // Bench asks for fundamental reset
  input wire logic [10:0] cfg, // Requested strap levels
  output logic fundamental_reset_n, // Fundamental reset, active low
  output logic [10:0] straps // Strap pin levels
);
  // Board powers up out of reset with every strap low
  logic run_n = 1'b1;
  logic [10:0] pins = 11'h000;
  // Straps move only under reset, never after its release
  always @(posedge pclk) begin
    run_n <= ~hold;
    if (hold) begin
      pins <= cfg;
    end
  end
  assign fundamental_reset_n = run_n;
  assign straps = pins;
endmodule
`default_nettype wire

//--- bench/tb_top.sv
/*
  Self-checking bench for the reset and strap control block.
  Assumes the board model drives straps and fundamental reset.
*/
`timescale 1ns/1ns
`default_nettype none
module tb_top;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic hold = 1'b0;
  logic [10:0] cfg = 11'h000;
  logic fund_n;
  logic [10:0] straps;
  logic [31:0] prdata;
  logic pready, pslverr, srst_n, fstart, smb_en, tick, slow, eep, rsv, usc;
  logic [3:0] eaddr;
  logic [1:0] dsc;
  logic [31:0] rd;
  logic er;
  int num_errors = 0;
  int n_tests = 0;
  int cyc = 0;

  always #4 pclk = ~pclk;

  srbsc_board i_srbsc_board (.pclk(pclk), .hold(hold), .cfg(cfg),
    .fundamental_reset_n(fund_n), .straps(straps));

  srbsc_top i_srbsc_top (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .fundamental_reset_n(fund_n),
    .downstream_common_clock_strap(straps[0]),
    .upstream_common_clock_strap(straps[1]),
    .master_smbus_slow_strap(straps[2]), .reset_halt_strap(straps[3]),
    .switch_op_mode_strap(straps[6:4]),
    .eeprom_smbus_address_strap(straps[10:7]), .switch_reset_n(srst_n),
    .pcie_fund_reset_start(fstart), .smbus_enable(smb_en),
    .msmb_tick(tick), .msmb_slow(slow), .eeprom_init_mode(eep),
    .mode_reserved(rsv), .eeprom_smbus_address(eaddr),
    .upstream_slot_clock(usc), .downstream_slot_clock(dsc));

  // ------------------------------------------------------------
  // Shared tasks
  // ------------------------------------------------------------
  task automatic final_report;
    $display("checks %0d mismatches %0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  // Whole run needs about 5000 cycles
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      num_errors++;
      final_report();
    end
  end

  task automatic cmp(input logic [31:0] g, input logic [31:0] e);
    n_tests++;
    if (g !== e) begin
      num_errors++;
      $display("mismatch at %0t: got %h expected %h", $time, g, e);
    end
  endtask

  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // Only the bench timeout ends a wait for the answer
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic boot(input logic [10:0] c);
    logic p;
    int n;
    p = 1'b0;
    @(posedge pclk);
    hold <= 1'b1;
    cfg <= c;
    repeat (6) begin
      @(posedge pclk);
      p = p | fstart;
    end
    cmp(p, 1);
    cmp({srst_n, smb_en}, 0);
    hold <= 1'b0;
    n = 0;
    while (smb_en !== 1'b1 && n < 300) begin
      @(posedge pclk);
      n++;
    end
    cmp(smb_en, 1);
    @(posedge pclk);
  endtask

  // ------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------
  task automatic t_straps;
    boot({4'ha, 3'h1, 1'b0, 1'b1, 1'b0, 1'b1});
    cmp(dsc, 2'b11);
    cmp(usc, 0);
    cmp({srst_n, slow, eep, rsv}, 4'b1110);
    cmp(eaddr, 4'ha);
    apb(1'b1, srbsc_pkg::OFS_DN2_LINK_STS, 32'h0);
    apb(1'b0, srbsc_pkg::OFS_DN4_LINK_STS, 32'h0);
    cmp(dsc, 2'b10);
    cmp(rd, 32'h1000);
    apb(1'b1, srbsc_pkg::OFS_DN4_LINK_STS, 32'h0);
    @(posedge pclk);
    cmp(dsc, 2'b00);
    apb(1'b1, srbsc_pkg::OFS_UP_LINK_STS, 32'h1000);
    apb(1'b0, srbsc_pkg::OFS_UP_LINK_STS, 32'h0);
    cmp(usc, 1);
    cmp(rd, 32'h1000);
    apb(1'b0, 12'h014, 32'h0);
    cmp(er, 1);
    cmp(rd, 32'h0);
    apb(1'b1, srbsc_pkg::OFS_STRAP_STS, 32'hffffffff);
    cmp(er, 0);
    apb(1'b0, srbsc_pkg::OFS_STRAP_STS, 32'h0);
    cmp(rd[13:0], 14'h3a29);
    $display("test straps done");
  endtask

  task automatic t_modes;
    logic [2:0] m;
    for (int i = 0; i < 8; i++) begin
      m = 3'(i);
      boot({4'h6, m, 1'b0, 1'b0, m[1], m[0]});
      cmp(eep, m == 3'h1);
      cmp(rsv, m >= 3'h2);
      cmp(eaddr, (m == 3'h1) ? 4'h6 : 4'h0);
      cmp(dsc, {2{m[0]}});
      cmp(usc, m[1]);
      cmp(slow, 0);
    end
    $display("test modes done");
  endtask

  task automatic t_halt;
    int n;
    boot({4'h0, 3'h0, 1'b1, 3'h0});
    cmp(srst_n, 0);
    apb(1'b0, srbsc_pkg::OFS_STRAP_STS, 32'h0);
    cmp(rd[13:12], 2'h2);
    apb(1'b0, srbsc_pkg::OFS_SWITCH_CTRL, 32'h0);
    cmp(rd, 32'h1);
    apb(1'b1, srbsc_pkg::OFS_SWITCH_CTRL, 32'h1);
    repeat (3) @(posedge pclk);
    cmp(srst_n, 0);
    apb(1'b1, srbsc_pkg::OFS_SWITCH_CTRL, 32'h0);
    n = 0;
    while (srst_n !== 1'b1 && n < 10) begin
      @(posedge pclk);
      n++;
    end
    cmp(srst_n, 1);
    $display("test halt done");
  endtask

  task automatic t_tick(input logic s);
    int n;
    boot({4'h0, 3'h0, 1'b0, s, 2'b00});
    n = 0;
    while (tick !== 1'b1 && n < 1500) begin
      @(posedge pclk);
      n++;
    end
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (tick !== 1'b1 && n < 1500);
    cmp(n, s ? 32'h4e2 : 32'h138);
    $display("test tick done");
  endtask

  initial begin
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    t_straps();
    t_modes();
    t_halt();
    t_tick(1'b1);
    t_tick(1'b0);
    final_report();
  end
endmodule
`default_nettype wire
